// ---- rtl/sac_params.svh ----
// Register offsets, field positions and timing counts for the converter control
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_ADDR_RESULT_LOW  8'hbe
`define SAC_ADDR_CONTROL     8'hc5
`define SAC_ADDR_RESULT_HIGH 8'hc6

`define SAC_CTL_RESET        8'h00
`define SAC_BIT_ENABLE       7
`define SAC_BIT_SPEED_HI     6
`define SAC_BIT_SPEED_LO     5
`define SAC_BIT_DONE         4
`define SAC_BIT_START        3
`define SAC_BIT_CHAN_HI      2

`define SAC_DIV_DIVIDER_SEL_LO       11'd1080
`define SAC_DIV_DIVIDER_SEL_HI       11'd810
`define SAC_DIV_SPEED2       11'd540
`define SAC_DIV_SPEED3       11'd270

`define SAC_CLK_MHZ          50
`define SAC_MAX_KSPS         100
`define SAC_MIN_DIV          (`SAC_CLK_MHZ * 1000 / `SAC_MAX_KSPS)
`define SAC_SAR_BITS         10
`define SAC_SYNC_WAIT        2'h2

`endif

// ---- rtl/sac_pkg.sv ----
// Types shared by the converter control files
package sac_pkg;
    typedef struct packed {
        logic       enable;
        logic [1:0] speed;
        logic       done;
        logic       start;
        logic [2:0] chan;
    } sac_ctl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_bus_t;

    typedef enum logic [1:0] {
        SAC_OFF,
        SAC_IDLE,
        SAC_CONV
    } sac_state_t;
endpackage : sac_pkg

// ---- rtl/sac_divider.sv ----
// Conversion clock divider: one enable pulse per divided period
`timescale 1ns/1ns
`include "sac_params.svh"
module sac_divider (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [1:0] speed,
    output logic            tick
);
    import sac_pkg::*;

    logic [10:0] cnt_ff;
    logic [10:0] nxt_cnt;
    logic [10:0] period;
    logic        nxt_tick;
    logic        tick_ff;

    always_comb begin
        unique case (speed)
            2'h0: period = `SAC_DIV_DIVIDER_SEL_LO;
            2'h1: period = `SAC_DIV_DIVIDER_SEL_HI;
            2'h2: period = `SAC_DIV_SPEED2;
            2'h3: period = `SAC_DIV_SPEED3;
        endcase
        // Never faster than the throughput ceiling
        if (period < 11'(`SAC_MIN_DIV)) begin
            period = 11'(`SAC_MIN_DIV);
        end
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff;
        if (!run) begin
            nxt_cnt = 11'h0;
        end else if (cnt_ff == period - 11'h1) begin
            nxt_cnt  = 11'h0;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 11'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= 11'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule : sac_divider

// ---- rtl/sac_sar.sv ----
// Successive-approximation bit search driven by the comparator
`timescale 1ns/1ns
`include "sac_params.svh"
module sac_sar (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       begin_conv,
    input  wire logic       comp_sync,
    output logic [9:0]      trial,
    output logic [9:0]      code,
    output logic            busy
);
    import sac_pkg::*;

    logic [9:0] trial_ff, nxt_trial;
    logic [9:0] code_ff,  nxt_code;
    logic [3:0] bit_ff,   nxt_bit;
    logic [1:0] wait_ff,  nxt_wait;
    logic       busy_ff,  nxt_busy;

    always_comb begin
        nxt_trial = trial_ff;
        nxt_code  = code_ff;
        nxt_bit   = bit_ff;
        nxt_wait  = wait_ff;
        nxt_busy  = busy_ff;
        if (begin_conv) begin
            nxt_trial = 10'h200;
            nxt_bit   = 4'(`SAC_SAR_BITS - 1);
            nxt_wait  = `SAC_SYNC_WAIT;
            nxt_busy  = 1'b1;
        end else if (busy_ff && wait_ff != 2'h0) begin
            // Comparator answer trails the trial by the synchroniser stages
            nxt_wait = wait_ff - 2'h1;
        end else if (busy_ff) begin
            // Keep the bit only if input is above the trial level
            nxt_trial[bit_ff] = comp_sync;
            if (bit_ff == 4'h0) begin
                nxt_busy = 1'b0;
                nxt_code = {trial_ff[9:1], comp_sync};
            end else begin
                nxt_trial[bit_ff - 4'h1] = 1'b1;
                nxt_bit = bit_ff - 4'h1;
                nxt_wait = `SAC_SYNC_WAIT;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trial_ff <= 10'h0;
            code_ff  <= 10'h0;
            bit_ff   <= 4'h0;
            wait_ff  <= 2'h0;
            busy_ff  <= 1'b0;
        end else begin
            trial_ff <= nxt_trial;
            code_ff  <= nxt_code;
            bit_ff   <= nxt_bit;
            wait_ff  <= nxt_wait;
            busy_ff  <= nxt_busy;
        end
    end

    assign trial = trial_ff;
    assign code  = code_ff;
    assign busy  = busy_ff;
endmodule : sac_sar

// ---- rtl/sac_adc_control.sv ----
// Converter control: register port, sequencing, result and interrupt request
`timescale 1ns/1ns
`include "sac_params.svh"
// Function
// RL1 - Converter runs only while enable bit set
// RL2 - Speed field picks divide 1080/810/540/270; code clamps 270 to 500
// RL3 - At most 100 ksps, one sample per period
// RL4 - Start bit set by software, cleared only by hardware
// RL5 - Completion clears start, sets done, loads result
// RL6 - No new start while start or done
// RL7 - Done set by hardware, software clears
// RL8 - Interrupt needs all three enables set
// RL9 - Channel field steers analog input mux
// RL10 - Result high bits 9:2, low bits 1:0
// RL11 - Unsigned left-justified 16-bit result word; code gives 10 bits, high register 9:2, low register bits 1:0 with 7:2 zero
// RL12 - Software waits 5us after enable
// RL13 - Software configures before starting conversions
// RL14 - No operation in power-down state
// RL15 - Software keeps converter clock under 12MHz
// RL16 - Channel and speed latched at start
module sac_adc_control (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire sac_pkg::sac_bus_t bus,
    input  wire logic             converter_irq_enable,
    input  wire logic             shared_serial_conv_irq_enable,
    input  wire logic             global_irq_enable,
    input  wire logic             power_down,
    input  wire logic             comp_in,
    output logic [7:0]            rdata,
    output logic [2:0]            analog_input_mux,
    output logic [9:0]            dac_trial,
    output logic                  analog_power_on,
    output logic                  sample_hold,
    output logic                  irq
);
    import sac_pkg::*;

    sac_ctl_t   ctl_ff,    nxt_ctl;
    sac_state_t state_ff,  nxt_state;
    logic [9:0] result_ff, nxt_result;
    logic [7:0] rdata_ff,  nxt_rdata;
    logic [2:0] mux_ff,    nxt_mux;
    logic [1:0] speed_ff,  nxt_speed;
    logic       irq_ff,    nxt_irq;
    logic       pwr_ff,    nxt_pwr;
    logic       sh_ff,     nxt_sh;
    logic       comp_meta_ff;
    logic       comp_sync_ff;
    logic       tick;
    logic       begin_conv;
    logic       sar_busy;
    logic [9:0] sar_code;
    logic [9:0] sar_trial;
    logic       wr_ctl;

    assign wr_ctl = bus.wr && (bus.addr == `SAC_ADDR_CONTROL);

    // Comparator is asynchronous to the core
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            comp_meta_ff <= 1'b0;
            comp_sync_ff <= 1'b0;
        end else begin
            comp_meta_ff <= comp_in;
            comp_sync_ff <= comp_meta_ff;
        end
    end

    // RL2 divided period
    sac_divider u_div (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (state_ff == SAC_CONV),
        .speed    (speed_ff),
        .tick     (tick)
    );

    sac_sar u_sar (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .begin_conv (begin_conv),
        .comp_sync  (comp_sync_ff),
        .trial      (sar_trial),
        .code       (sar_code),
        .busy       (sar_busy)
    );

    always_comb begin
        nxt_ctl    = ctl_ff;
        nxt_state  = state_ff;
        nxt_result = result_ff;
        nxt_mux    = mux_ff;
        nxt_speed  = speed_ff;
        begin_conv = 1'b0;
        if (wr_ctl) begin
            nxt_ctl.enable = bus.wdata[`SAC_BIT_ENABLE];
            nxt_ctl.speed  = bus.wdata[`SAC_BIT_SPEED_HI:`SAC_BIT_SPEED_LO];
            nxt_ctl.chan   = bus.wdata[`SAC_BIT_CHAN_HI:0];
            // RL7 software clears done
            if (!bus.wdata[`SAC_BIT_DONE]) begin
                nxt_ctl.done = 1'b0;
            end
            // RL4 start only settable; RL6 refused while start or done
            if (bus.wdata[`SAC_BIT_START] && !ctl_ff.start && !ctl_ff.done
                && bus.wdata[`SAC_BIT_ENABLE] && !power_down) begin
                nxt_ctl.start = 1'b1;
            end
        end
        unique case (state_ff)
            SAC_OFF: begin
                if (ctl_ff.enable && !power_down) begin
                    nxt_state = SAC_IDLE;
                end
            end
            SAC_IDLE: begin
                if (ctl_ff.start) begin
                    // RL16 latch channel and speed
                    nxt_mux    = ctl_ff.chan;
                    nxt_speed  = ctl_ff.speed;
                    nxt_state  = SAC_CONV;
                end
            end
            SAC_CONV: begin
                // RL3 one sample per divided period
                if (tick && !sar_busy) begin
                    // RL5 clear start, set done, load result together
                    nxt_ctl.start = 1'b0;
                    nxt_ctl.done  = 1'b1;
                    nxt_result    = sar_code;
                    nxt_state     = SAC_IDLE;
                end
            end
        endcase
        // RL1 RL14 shutdown aborts and holds off
        if (!nxt_ctl.enable || power_down) begin
            nxt_state     = SAC_OFF;
            nxt_ctl.start = 1'b0;
        end
        // No sample is taken once shutdown is pending
        begin_conv = (state_ff == SAC_IDLE) && (nxt_state == SAC_CONV);
        if (nxt_state == SAC_IDLE && state_ff == SAC_OFF) begin
            nxt_mux = ctl_ff.chan;
        end
    end

    always_comb begin
        // RL10 RL11 left-justified split result
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                `SAC_ADDR_CONTROL:     nxt_rdata = nxt_ctl;
                `SAC_ADDR_RESULT_HIGH: nxt_rdata = result_ff[9:2];
                `SAC_ADDR_RESULT_LOW:  nxt_rdata = {6'h00, result_ff[1:0]};
                default:               nxt_rdata = 8'h00;
            endcase
        end
        // RL8 all three enables gate the request
        nxt_irq = ctl_ff.done && converter_irq_enable
                  && shared_serial_conv_irq_enable && global_irq_enable;
        nxt_pwr = ctl_ff.enable && !power_down;
        nxt_sh  = begin_conv;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_ff    <= `SAC_CTL_RESET;
            state_ff  <= SAC_OFF;
            result_ff <= 10'h0;
            rdata_ff  <= 8'h00;
            mux_ff    <= 3'h0;
            speed_ff  <= 2'h0;
            irq_ff    <= 1'b0;
            pwr_ff    <= 1'b0;
            sh_ff     <= 1'b0;
        end else begin
            ctl_ff    <= nxt_ctl;
            state_ff  <= nxt_state;
            result_ff <= nxt_result;
            rdata_ff  <= nxt_rdata;
            mux_ff    <= nxt_mux;
            speed_ff  <= nxt_speed;
            irq_ff    <= nxt_irq;
            pwr_ff    <= nxt_pwr;
            sh_ff     <= nxt_sh;
        end
    end

    // RL9 channel steers the multiplexer
    assign analog_input_mux = mux_ff;
    assign dac_trial        = sar_trial;
    assign analog_power_on  = pwr_ff;
    assign sample_hold      = sh_ff;
    assign irq              = irq_ff;
    assign rdata            = rdata_ff;
endmodule : sac_adc_control

// ---- test/sac_afe_model.sv ----
// Comparator and input mux stand-in for the converter core
`timescale 1ns/1ns
module sac_afe_model (
    input  wire logic       core_clk,
    input  wire logic [2:0] analog_input_mux,
    input  wire logic [9:0] dac_trial,
    input  wire logic       analog_power_on,
    output logic            comp_in
);
    logic [9:0] level [8];
    logic       idle_ff = 1'b0;
    initial for (int k = 0; k < 8; k++) level[k] = 10'h200;
    always @(posedge core_clk) idle_ff <= ~idle_ff;
    // pin n on code n
    // Level sits half a step above its code, so equal counts as above
    // unpowered core toggles
    assign comp_in = analog_power_on ? (level[analog_input_mux] >= dac_trial) : idle_ff;
endmodule : sac_afe_model

// ---- test/sac_adc_control_sva.sv ----
// Port assertions for the converter control
`timescale 1ns/1ns
`include "sac_params.svh"
module sac_adc_control_sva
    import sac_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire sac_bus_t   bus,
    input wire logic       converter_irq_enable,
    input wire logic       shared_serial_conv_irq_enable,
    input wire logic       global_irq_enable,
    input wire logic       power_down,
    input wire logic [7:0] rdata,
    input wire logic [2:0] analog_input_mux,
    input wire logic       analog_power_on,
    input wire logic       sample_hold,
    input wire logic       irq
);
    logic [9:0] gap_ff;
    logic [9:0] nxt_gap;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Saturates so an idle converter never wraps into a false short gap
    always_comb begin
        nxt_gap = sample_hold ? 10'h000 : gap_ff + {9'h000, gap_ff != 10'h3ff};
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) gap_ff <= 10'h3ff;
        else gap_ff <= nxt_gap;
    end
    sequence s_ctl_off;
        bus.wr && bus.addr == `SAC_ADDR_CONTROL && !bus.wdata[7];
    endsequence
    sequence s_rd_unmapped;
        bus.rd && bus.addr != `SAC_ADDR_CONTROL && bus.addr != `SAC_ADDR_RESULT_HIGH
            && bus.addr != `SAC_ADDR_RESULT_LOW;
    endsequence
    a_enable_gates_power: assert property (s_ctl_off |-> ##2 !analog_power_on)
        else $error("core powered after disable");
    a_pd_forces_off: assert property (power_down |=> !analog_power_on)
        else $error("core powered in power-down");
    a_hold_needs_power: assert property (sample_hold |-> analog_power_on)
        else $error("sample taken while unpowered");
    a_hold_one_pulse: assert property (sample_hold |=> !sample_hold)
        else $error("sample pulse longer than one cycle");
    a_sample_rate_cap: assert property (sample_hold |-> gap_ff >= 10'd500)
        else $error("samples closer than rate limit");
    a_mux_held_conv: assert property (sample_hold |=> $stable(analog_input_mux) [*8])
        else $error("channel moved during conversion");
    a_rdata_idle_zero: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data without read");
    a_unmapped_zero: assert property (s_rd_unmapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_needs_enables: assert property (irq |-> $past(converter_irq_enable)
        && $past(shared_serial_conv_irq_enable) && $past(global_irq_enable))
        else $error("interrupt with an enable clear");
endmodule : sac_adc_control_sva
bind sac_adc_control sac_adc_control_sva i_sac_adc_control_sva (.*);

// ---- test/tb.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ns
`include "sac_params.svh"
module tb;
    import sac_pkg::*;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    sac_bus_t   bus;
    logic [2:0] en;
    logic       power_down;
    logic       comp_in;
    logic [7:0] rdata;
    logic [2:0] mux;
    logic [9:0] dac_trial;
    logic       pwr;
    logic       sample_hold;
    logic       irq;
    logic [31:0] rnd = 32'h1da6e553;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc++;
    sac_adc_control i_sac_adc_control (.core_clk(core_clk), .rstn(rstn), .bus(bus),
        .converter_irq_enable(en[0]), .shared_serial_conv_irq_enable(en[1]),
        .global_irq_enable(en[2]), .power_down(power_down), .comp_in(comp_in),
        .rdata(rdata), .analog_input_mux(mux), .dac_trial(dac_trial),
        .analog_power_on(pwr), .sample_hold(sample_hold), .irq(irq));
    sac_afe_model i_sac_afe_model (.core_clk(core_clk), .analog_input_mux(mux),
        .dac_trial(dac_trial), .analog_power_on(pwr), .comp_in(comp_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int eff_div(input logic [1:0] s);
        int d;
        d = (s == 2'd0) ? 1080 : (s == 2'd1) ? 810 : (s == 2'd2) ? 540 : 270;
        return (d < `SAC_MIN_DIV) ? `SAC_MIN_DIV : d;
    endfunction : eff_div
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] d);
        bus.wr = 1'b1;
        bus.addr = `SAC_ADDR_CONTROL;
        bus.wdata = d;
        step();
        bus.wr = 1'b0;
        step();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus.rd = 1'b1;
        bus.addr = a;
        step();
        d = rdata;
        bus.rd = 1'b0;
        step();
    endtask : rd
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial begin
        // About two and a half times the expected run of some 7500 cycles
        #400_000;
        err_total++;
        finish_test();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [2:0] ch;
        logic [1:0] sp;
        logic [9:0] code;
        int         t0;
        bus = '0;
        en = 3'b111;
        power_down = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1'b1;
        rd(`SAC_ADDR_CONTROL, v);
        chk("ctl_reset", {8'h00, `SAC_CTL_RESET}, {8'h00, v});
        rd(8'h00, v);
        chk("unmapped", 16'h0000, {8'h00, v});
        // 5us of enable before any start
        wr(8'h80);
        repeat (250) step();
        power_down = 1'b1;
        wr(8'h88);
        chk("pd_power", 16'h0000, {15'h0000, pwr});
        rd(`SAC_ADDR_CONTROL, v);
        chk("pd_start", 16'h0080, {8'h00, v});
        power_down = 1'b0;
        repeat (250) step();
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            ch = (i == 4) ? 3'd7 : (i == 5) ? 3'd0 : rnd[2:0];
            // every divider setting in turn, each at or under the 100 ksps cap
            sp = i[1:0];
            code = (i == 4) ? 10'h3ff : (i == 5) ? 10'h000 : rnd[17:8];
            for (int k = 0; k < 8; k++) i_sac_afe_model.level[k] = ~code;
            i_sac_afe_model.level[ch] = code;
            en = {i != 1, rnd[20] | (i != 2), 1'b1};
            wr({1'b1, sp, 2'b01, ch});
            t0 = cyc;
            wr({1'b1, sp, 2'b00, ~ch});
            v = 8'h00;
            while (v[4] !== 1'b1 && cyc - t0 < 1200) rd(`SAC_ADDR_CONTROL, v);
            chk("conv_time", 16'h0001, {15'h0000, cyc - t0 >= eff_div(sp) - 2
                && cyc - t0 <= eff_div(sp) + 12});
            chk("ctl_done", {8'h00, 1'b1, sp, 2'b10, ~ch}, {8'h00, v});
            chk("irq", {15'h0000, &en}, {15'h0000, irq});
            wr({1'b1, sp, 2'b11, ch});
            repeat (4) step();
            rd(`SAC_ADDR_CONTROL, v);
            chk("restart", {8'h00, 1'b1, sp, 2'b10, ch}, {8'h00, v});
            rd(`SAC_ADDR_RESULT_HIGH, hi);
            rd(`SAC_ADDR_RESULT_LOW, lo);
            chk("result", {code[9:2], 6'h00, code[1:0]}, {hi, lo});
            wr({1'b1, sp, 2'b00, ch});
            step();
            chk("irq_clr", 16'h0000, {15'h0000, irq});
            repeat (250) step();
        end
        wr(8'h89);
        repeat (20) step();
        wr(8'h09);
        step();
        chk("off_power", 16'h0000, {15'h0000, pwr});
        rd(`SAC_ADDR_CONTROL, v);
        chk("abort", 16'h0001, {8'h00, v});
        // Reset in mid-conversion drops it and clears the control word
        wr(8'h80);
        repeat (500) step();
        wr(8'h8a);
        repeat (20) step();
        rstn = 1'b0;
        repeat (2) step();
        rstn = 1'b1;
        chk("rst_power", 16'h0000, {15'h0000, pwr});
        rd(`SAC_ADDR_CONTROL, v);
        chk("rst_ctl", 16'h0000, {8'h00, v});
        finish_test();
    end
endmodule : tb
